/* File: core/rmd_consts.vh */
// Constants for the rotate and move datapath: opcodes, fields, phases.
// Assumes it is included by bare name from files under core/.
`ifndef RMD_CONSTS_VH
`define RMD_CONSTS_VH
`define RMD_OP_MOVE_WORK_TO_FILE 7'h00
`define RMD_MOVE_CODE_BIT 1'h1
`define RMD_OP_ROTATE_LEFT_NO_CARRY 7'h11
`define RMD_OP_ROTATE_RIGHT_THRU_CARRY 7'h0C
`define RMD_OPC_MSB 15
`define RMD_OPC_LSB 9
`define RMD_DEST_BIT 8
`define RMD_ADDR_MSB 7
`define RMD_ADDR_LSB 0
`define RMD_PH_DECODE 2'h0
`define RMD_PH_READ 2'h1
`define RMD_PH_EXECUTE 2'h2
`define RMD_PH_WRITE 2'h3
`define RMD_WORK_RESET 8'h00
`define RMD_CARRY_RESET 1'h0
`endif

/* File: core/rmd_shifter.v */
// Combinational rotate unit for one 8-bit operand.
// Assumes the caller registers both the result and the carry out.
`default_nettype none
module rmd_shifter #(
	parameter WIDTH = 8
) (
	input  wire [WIDTH-1:0] operand_in,
	input  wire             carry_in,
	input  wire             right_in,
	output wire [WIDTH-1:0] result_out,
	output wire             carry_out
);
	// Left wraps the top bit; right pulls the carry in as a ninth bit.
	assign result_out = right_in ? {carry_in, operand_in[WIDTH-1:1]} :
		{operand_in[WIDTH-2:0], operand_in[WIDTH-1]};
	assign carry_out = right_in ? operand_in[0] : carry_in;
endmodule // rmd_shifter
`default_nettype wire

/* File: core/rmd_datapath.v */
// Execution datapath for move-working-to-file and two rotates.
// Assumes an outside file memory answers a read within the read phase.
// Summary of operation
// - Rotate left shifts file byte left, bit 7 into bit 0, flags kept.
// - Rotate left with destination 0 writes working register only.
// - Rotate left with destination 1 writes the source file register.
// - Rotate right moves bit 0 to carry, old carry into bit 7.
// - Rotate right with destination 0 writes working register only.
// - Rotate right with destination 1 writes the source file register.
// - Rotate right uses carry as ninth bit; carry is its only flag.
`default_nettype none
`include "rmd_consts.vh"
module rmd_datapath #(
	parameter WIDTH = 8,
	parameter AW    = 8
) (
	input  wire             sys_clk_in,
	input  wire             nrst_in,
	input  wire [15:0]      instr_in,
	input  wire             instr_valid_in,
	input  wire [WIDTH-1:0] file_rdata_in,
	output wire             instr_ready_out,
	output reg  [AW-1:0]    file_addr_out,
	output reg              file_rd_out,
	output reg              file_wr_out,
	output reg  [WIDTH-1:0] file_wdata_out,
	output wire [WIDTH-1:0] working_register_out,
	output wire             carry_out,
	output reg              done_out
);
	localparam OP_NONE = 2'h0;
	localparam OP_MOVE = 2'h1;
	localparam OP_RLN  = 2'h2;
	localparam OP_RRC  = 2'h3;

	// Sequencer states, one clock each, four to an instruction.
	localparam PH_DECODE  = `RMD_PH_DECODE;
	localparam PH_READ    = `RMD_PH_READ;
	localparam PH_EXECUTE = `RMD_PH_EXECUTE;
	localparam PH_WRITE   = `RMD_PH_WRITE;

	// The move owns its whole top byte, so bit 8 is part of its code;
	// matching on seven bits alone would also take an unrelated word.
	function [1:0] decode_op;
		input [6:0] opc;
		input       low_bit;
		begin
			if (opc == `RMD_OP_MOVE_WORK_TO_FILE &&
				low_bit == `RMD_MOVE_CODE_BIT)
				decode_op = OP_MOVE;
			else if (opc == `RMD_OP_ROTATE_LEFT_NO_CARRY)
				decode_op = OP_RLN;
			else if (opc == `RMD_OP_ROTATE_RIGHT_THRU_CARRY)
				decode_op = OP_RRC;
			else
				decode_op = OP_NONE;
		end
	endfunction

	// A result goes to the file unless it is a rotate aimed at the
	// working register.
	function to_file;
		input [1:0] op;
		input       dest;
		begin
			if (op == OP_MOVE)
				to_file = 1'h1;
			else
				to_file = dest;
		end
	endfunction

	reg [1:0]        phase_ff;
	reg [1:0]        op_ff;
	reg              dest_ff;
	reg [AW-1:0]     addr_ff;
	reg [WIDTH-1:0]  operand_ff;
	reg [WIDTH-1:0]  result_ff;
	reg              res_carry_ff;
	reg [WIDTH-1:0]  working_register_ff;
	reg              carry_ff;
	reg [1:0]        nxt_phase;
	reg [1:0]        nxt_op;
	reg              nxt_dest;
	reg [AW-1:0]     nxt_addr;
	reg [WIDTH-1:0]  nxt_operand;
	reg [WIDTH-1:0]  nxt_result;
	reg              nxt_res_carry;
	reg [WIDTH-1:0]  nxt_working_register;
	reg              nxt_carry;
	reg [AW-1:0]     nxt_file_addr;
	reg              nxt_file_rd;
	reg              nxt_file_wr;
	reg [WIDTH-1:0]  nxt_file_wdata;
	reg              nxt_done;
	wire [1:0]       instr_op;
	wire [WIDTH-1:0] shift_res;
	wire             shift_carry;

	assign instr_op = decode_op(instr_in[`RMD_OPC_MSB:`RMD_OPC_LSB],
		instr_in[`RMD_DEST_BIT]);

	// An instruction is only taken at the start of a cycle, so the
	// four phases of one never overlap those of the next.
	assign instr_ready_out = (phase_ff == PH_DECODE);
	assign working_register_out = working_register_ff;
	assign carry_out = carry_ff;

	rmd_shifter #(
		.WIDTH(WIDTH)
	) u_shift (
		.operand_in(operand_ff),
		.carry_in  (carry_ff),
		.right_in  (op_ff == OP_RRC),
		.result_out(shift_res),
		.carry_out (shift_carry)
	);

	// Everything holds unless its phase says otherwise; strobes drop.
	always @* begin
		nxt_phase            = phase_ff;
		nxt_op               = op_ff;
		nxt_dest             = dest_ff;
		nxt_addr             = addr_ff;
		nxt_operand          = operand_ff;
		nxt_result           = result_ff;
		nxt_res_carry        = res_carry_ff;
		nxt_working_register = working_register_ff;
		nxt_carry            = carry_ff;
		nxt_file_addr        = file_addr_out;
		nxt_file_rd          = 1'h0;
		nxt_file_wr          = 1'h0;
		nxt_file_wdata       = file_wdata_out;
		nxt_done             = 1'h0;
		case (phase_ff)
		PH_DECODE: begin
			if (instr_valid_in && instr_op != OP_NONE) begin
				nxt_op        = instr_op;
				nxt_dest      = instr_in[`RMD_DEST_BIT];
				nxt_addr      = instr_in[`RMD_ADDR_MSB:`RMD_ADDR_LSB];
				nxt_file_addr = instr_in[`RMD_ADDR_MSB:`RMD_ADDR_LSB];
				nxt_file_rd   = 1'h1;
				nxt_phase     = PH_READ;
			end
		end
		PH_READ: begin
			nxt_operand = file_rdata_in;
			nxt_phase   = PH_EXECUTE;
		end
		PH_EXECUTE: begin
			// The move ignores the operand read; the read keeps
			// the phase pattern uniform across all three.
			if (op_ff == OP_MOVE) begin
				nxt_result    = working_register_ff;
				nxt_res_carry = carry_ff;
			end else begin
				nxt_result    = shift_res;
				nxt_res_carry = shift_carry;
			end
			nxt_phase = PH_WRITE;
		end
		default: begin
			if (to_file(op_ff, dest_ff)) begin
				nxt_file_addr  = addr_ff;
				nxt_file_wdata = result_ff;
				nxt_file_wr    = 1'h1;
			end
			if (!to_file(op_ff, dest_ff))
				nxt_working_register = result_ff;
			if (op_ff == OP_RRC)
				nxt_carry = res_carry_ff;
			nxt_done  = 1'h1;
			nxt_phase = PH_DECODE;
		end
		endcase
	end

	// Sequencer and the fields latched from the instruction word.
	always @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			phase_ff <= PH_DECODE;
			op_ff    <= OP_NONE;
			dest_ff  <= 1'h0;
			addr_ff  <= {AW{1'h0}};
		end else begin
			phase_ff <= nxt_phase;
			op_ff    <= nxt_op;
			dest_ff  <= nxt_dest;
			addr_ff  <= nxt_addr;
		end
	end

	// Operand, staged result and the two visible registers.
	always @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			operand_ff          <= {WIDTH{1'h0}};
			result_ff           <= {WIDTH{1'h0}};
			res_carry_ff        <= `RMD_CARRY_RESET;
			working_register_ff <= `RMD_WORK_RESET;
			carry_ff            <= `RMD_CARRY_RESET;
		end else begin
			operand_ff          <= nxt_operand;
			result_ff           <= nxt_result;
			res_carry_ff        <= nxt_res_carry;
			working_register_ff <= nxt_working_register;
			carry_ff            <= nxt_carry;
		end
	end

	// Memory strobes come from flip-flops so they never glitch.
	always @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			file_addr_out  <= {AW{1'h0}};
			file_rd_out    <= 1'h0;
			file_wr_out    <= 1'h0;
			file_wdata_out <= {WIDTH{1'h0}};
			done_out       <= 1'h0;
		end else begin
			file_addr_out  <= nxt_file_addr;
			file_rd_out    <= nxt_file_rd;
			file_wr_out    <= nxt_file_wr;
			file_wdata_out <= nxt_file_wdata;
			done_out       <= nxt_done;
		end
	end
endmodule // rmd_datapath
`default_nettype wire

/* File: verification/rmd_datapath_assertions.sv */
// Checker for the datapath, bound to its top ports.
// Assumes one clock and a synchronous active low reset.
`default_nettype none
`include "rmd_consts.vh"
module rmd_datapath_assertions (
	input wire logic        sys_clk_in,
	input wire logic        nrst_in,
	input wire logic [15:0] instr_in,
	input wire logic        instr_valid_in,
	input wire logic [7:0]  file_rdata_in,
	input wire logic        instr_ready_out,
	input wire logic        file_rd_out,
	input wire logic        file_wr_out,
	input wire logic [7:0]  file_wdata_out,
	input wire logic        carry_out,
	input wire logic        done_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!nrst_in);
	wire [6:0] op = instr_in[15:9];
	wire       mv = op == `RMD_OP_MOVE_WORK_TO_FILE &&
		instr_in[8] == `RMD_MOVE_CODE_BIT;
	wire       tk = instr_ready_out && instr_valid_in && (mv ||
		op == `RMD_OP_ROTATE_LEFT_NO_CARRY ||
		op == `RMD_OP_ROTATE_RIGHT_THRU_CARRY);
	logic [7:0] f_ff;
	logic [7:0] op_ff;
	// Operand and opcode are kept so results can be checked at the end.
	always @(posedge sys_clk_in) begin
		if (file_rd_out)
			f_ff <= file_rdata_in;
		if (tk)
			op_ff <= instr_in[15:8];
	end
	sequence s_take;
		tk;
	endsequence
	sequence s_move;
		tk && mv;
	endsequence
	sequence s_left;
		tk && op == `RMD_OP_ROTATE_LEFT_NO_CARRY;
	endsequence
	sequence s_right;
		tk && op == `RMD_OP_ROTATE_RIGHT_THRU_CARRY;
	endsequence
	read_pulse_a: assert property (s_take |-> ##1 file_rd_out)
		else $error("no read after issue");
	end_pulse_a: assert property (s_take |-> ##4 done_out)
		else $error("no done four cycles after issue");
	move_wr_a: assert property (s_move |-> ##4 file_wr_out)
		else $error("move did not write");
	left_dest_a: assert property (s_left |->
		##4 file_wr_out == $past(instr_in[8], 4))
		else $error("rotate left destination wrong");
	right_dest_a: assert property (s_right |->
		##4 file_wr_out == $past(instr_in[8], 4))
		else $error("rotate right destination wrong");
	left_val_a: assert property (done_out && file_wr_out &&
		op_ff[7:1] == `RMD_OP_ROTATE_LEFT_NO_CARRY |->
		file_wdata_out == {f_ff[6:0], f_ff[7]})
		else $error("rotate left value");
	right_carry_a: assert property (done_out &&
		op_ff[7:1] == `RMD_OP_ROTATE_RIGHT_THRU_CARRY |-> carry_out == f_ff[0])
		else $error("carry not from bit 0");
	flag_keep_a: assert property (done_out &&
		op_ff[7:1] != `RMD_OP_ROTATE_RIGHT_THRU_CARRY |-> $stable(carry_out))
		else $error("carry changed without rotate right");
	carry_hold_a: assert property (!done_out |-> $stable(carry_out))
		else $error("carry changed mid instruction");
endmodule // rmd_datapath_assertions
`default_nettype wire

/* File: verification/rmd_datapath_bench.sv */
// Self-checking bench for the datapath with a reference model.
// Assumes the bench plays the file memory.
`default_nettype none
`include "rmd_consts.vh"
module rmd_datapath_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, nrst = 0, vld = 0, c = 0, rq, wr, rr, dn, co;
	logic [15:0] ins = 0;
	logic [7:0] rd = 0, w = 0, ad, wd, wo;
	logic [6:0] ops [3] = '{`RMD_OP_MOVE_WORK_TO_FILE,
		`RMD_OP_ROTATE_LEFT_NO_CARRY, `RMD_OP_ROTATE_RIGHT_THRU_CARRY};
	int failures = 0, cmp_count = 0, cyc = 0;
	always #2 clk = ~clk;
	rmd_datapath u_rmd_datapath (.sys_clk_in(clk), .nrst_in(nrst),
		.instr_in(ins), .instr_valid_in(vld), .file_rdata_in(rd),
		.instr_ready_out(rq), .file_addr_out(ad), .file_rd_out(rr),
		.file_wr_out(wr), .file_wdata_out(wd), .working_register_out(wo),
		.carry_out(co), .done_out(dn));
	task chk(string n, logic [7:0] e, logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task results;
		$display("checks %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge clk) if (++cyc > 3000) begin
		failures++;
		results;
	end
	task run(logic [6:0] op, logic d, logic [7:0] a, logic [7:0] f);
		logic [7:0] r;
		int k;
		// The move keeps bit 8 set, as it is part of its code.
		if (op == ops[0])
			d = `RMD_MOVE_CODE_BIT;
		@(negedge clk) ins = {op, d, a};
		vld = 1;
		@(negedge clk) vld = 0;
		rd = f;
		chk("rd", 8'h01, {7'h00, rr});
		chk("raddr", a, ad);
		// Read data is scrambled once sampled so a late capture shows.
		@(negedge clk) rd = ~f;
		chk("ready", 8'h00, {7'h00, rq});
		r = op == ops[1] ? {f[6:0], f[7]} : {c, f[7:1]};
		if (op == ops[2])
			c = f[0];
		k = 0;
		while (dn !== 1'b1 && k < 6) begin
			@(negedge clk);
			k++;
		end
		chk("done", 8'h01, {7'h00, dn});
		chk("cycles", 8'h04, 8'(k + 2));
		chk("ready", 8'h01, {7'h00, rq});
		chk("wr", {7'h00, op == ops[0] || d}, {7'h00, wr});
		if (op == ops[0] || d)
			chk("wdata", op == ops[0] ? w : r, wd);
		if (op == ops[0] || d)
			chk("waddr", a, ad);
		if (op != ops[0] && !d)
			w = r;
		chk("working_register", w, wo);
		chk("carry", {7'h00, c}, {7'h00, co});
	endtask
	// A word that decodes to nothing must start no cycle at all.
	task refuse(logic [15:0] i);
		int k;
		@(negedge clk) ins = i;
		vld = 1;
		@(negedge clk) vld = 0;
		chk("refused rd", 8'h00, {7'h00, rr});
		for (k = 0; k < 4; k++) begin
			@(negedge clk);
			chk("refused done", 8'h00, {7'h00, dn});
			chk("refused ready", 8'h01, {7'h00, rq});
		end
	endtask
	initial begin
		void'($urandom(68705));
		repeat (12) @(negedge clk);
		nrst = 1;
		repeat (4) begin
			// Move code with bit 8 clear, then an unused opcode.
			refuse({`RMD_OP_MOVE_WORK_TO_FILE, 1'h0, 8'($urandom)});
			refuse({7'h7F, 9'($urandom)});
			repeat (15) run(ops[$urandom % 3], $urandom,
				$urandom, $urandom);
		end
		results;
	end
endmodule // rmd_datapath_bench
bind rmd_datapath rmd_datapath_assertions u_chk (.*);
`default_nettype wire
